// *** pkg/prc_pkg.sv ***
// periodic real-time counter: register map, field layout, reset values and divide table
// assumes a single bus clock domain and 8-bit registers on a plain strobe port
package prc_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int unsigned PRC_ADDR_W = 2;
  localparam logic [PRC_ADDR_W-1:0] PRC_OFS_STATUS_CONTROL = 2'h0;
  localparam logic [PRC_ADDR_W-1:0] PRC_OFS_COUNT_VALUE = 2'h1;
  localparam logic [PRC_ADDR_W-1:0] PRC_OFS_MODULO_VALUE = 2'h2;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int unsigned PRC_BIT_MATCH_FLAG = 7;
  localparam int unsigned PRC_BIT_IRQ_ENABLE = 4;
  localparam int unsigned PRC_CLKS_LSB = 5;
  localparam int unsigned PRC_PS_LSB = 0;
  localparam logic [1:0] PRC_CLKS_RESET = 2'h0;
  localparam logic [3:0] PRC_PS_RESET = 4'h0;
  localparam logic [7:0] PRC_COUNT_RESET = 8'h00;
  localparam logic [7:0] PRC_MODULO_RESET = 8'h00;
  localparam int unsigned PRC_RATIO_W = 18;
  localparam logic [PRC_RATIO_W-1:0] PRC_RATIO_OFF = 18'h00000;

  // clock source index into the synchronised source vector
  localparam int unsigned PRC_SRC_LPO = 0;
  localparam int unsigned PRC_SRC_EXT = 1;
  localparam int unsigned PRC_SRC_IRC = 2;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic match_flag;
    logic [1:0] count_clock_select;
    logic match_irq_enable;
    logic [3:0] prescale_select;
  } prc_ctrl_s;

  localparam prc_ctrl_s PRC_CTRL_RESET = '{1'b0, PRC_CLKS_RESET, 1'b0, PRC_PS_RESET};

  typedef struct packed {
    logic [PRC_ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } prc_bus_req_s;

  // ----------------------------------------------------------------
  // divide ratio per select bit 0 and prescaler code, 0 means stopped
  // ----------------------------------------------------------------
  function automatic logic [PRC_RATIO_W-1:0] prc_ratio(input logic clks0, input logic [3:0] ps);
    logic [PRC_RATIO_W-1:0] r;
    r = PRC_RATIO_OFF;
    if (!clks0)
    begin
      unique case (ps)
        4'h0: r = 18'd0;
        4'h1: r = 18'd8;
        4'h2: r = 18'd32;
        4'h3: r = 18'd64;
        4'h4: r = 18'd128;
        4'h5: r = 18'd256;
        4'h6: r = 18'd512;
        4'h7: r = 18'd1024;
        4'h8: r = 18'd1;
        4'h9: r = 18'd2;
        4'ha: r = 18'd4;
        4'hb: r = 18'd10;
        4'hc: r = 18'd16;
        4'hd: r = 18'd100;
        4'he: r = 18'd500;
        4'hf: r = 18'd1000;
      endcase
    end
    else
    begin
      unique case (ps)
        4'h0: r = 18'd0;
        4'h1: r = 18'd1024;
        4'h2: r = 18'd2048;
        4'h3: r = 18'd4096;
        4'h4: r = 18'd8192;
        4'h5: r = 18'd16384;
        4'h6: r = 18'd32768;
        4'h7: r = 18'd65536;
        4'h8: r = 18'd1000;
        4'h9: r = 18'd2000;
        4'ha: r = 18'd5000;
        4'hb: r = 18'd10000;
        4'hc: r = 18'd20000;
        4'hd: r = 18'd50000;
        4'he: r = 18'd100000;
        4'hf: r = 18'd200000;
      endcase
    end
    return r;
  endfunction : prc_ratio

endpackage : prc_pkg

// *** rtl/prc_prescaler.sv ***
// prescaler: counts edges of the selected source and pulses once per ratio edges
// assumes i_step is a one-cycle pulse already in the bus clock domain
`timescale 1ns/1ps
`default_nettype none
module prc_prescaler
  import prc_pkg::*;
#(
  parameter int unsigned RATIO_W = PRC_RATIO_W
)
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_clk_en,
  input wire logic i_step,
  input wire logic i_clear,
  input wire logic [RATIO_W-1:0] i_ratio,
  output logic o_tick
);

  // ----------------------------------------------------------------
  // divider
  // ----------------------------------------------------------------
  logic [RATIO_W-1:0] div_count;
  logic [RATIO_W-1:0] next_div_count;
  logic last_step;

  assign next_div_count = div_count + {{(RATIO_W-1){1'b0}}, 1'b1};
  assign last_step = (next_div_count == i_ratio);

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      div_count <= '0;
      o_tick <= 1'b0;
    end
    else if (i_clk_en)
    begin
      if (i_clear)
      begin
        div_count <= '0;
        o_tick <= 1'b0;
      end
      // ratio zero holds the divider: prescaler off
      else if (i_step && (i_ratio != '0))
      begin
        div_count <= last_step ? '0 : next_div_count;
        o_tick <= last_step;
      end
      else
      begin
        o_tick <= 1'b0;
      end
    end
  end

endmodule : prc_prescaler
`default_nettype wire

// *** rtl/prc_top.sv ***
// periodic real-time counter: registers, source select, match logic, irq and adc trigger
// assumes one bus clock; counting clocks arrive as slow pins and are sampled here
`timescale 1ns/1ps
`default_nettype none
module prc_top
  import prc_pkg::*;
#(
  parameter int unsigned CNT_W = 8
)
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_clk_en,
  input wire logic i_bus_clock_gate,
  input wire logic i_debug_active,
  input wire logic i_deep_stop_mode,
  input wire logic i_adc_hw_trigger_enable,
  input wire logic i_low_power_osc_clock,
  input wire logic i_external_ref_clock,
  input wire logic i_internal_ref_clock,
  input wire logic [PRC_ADDR_W-1:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  output logic o_irq,
  output logic o_adc_trigger
);

  // ----------------------------------------------------------------
  // bus request
  // ----------------------------------------------------------------
  prc_bus_req_s req;
  logic wr_ok;
  logic rd_ok;

  assign req = '{i_addr, i_wdata, i_wr, i_rd};
  // with the bus clock gated off the block sees no register access
  assign wr_ok = req.wr && i_bus_clock_gate;
  assign rd_ok = req.rd && i_bus_clock_gate;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  prc_ctrl_s ctrl;
  logic match_flag;
  logic [1:0] count_clock_select;
  logic match_irq_enable;
  logic [3:0] prescale_select;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] modulo;

  logic ctrl_wr;
  logic mod_wr;
  logic clear_flag_wr;
  logic [1:0] wr_clks;
  logic [3:0] wr_ps;
  logic sel_changed;
  logic counters_clear;

  // flag and settings live in separate processes, so each field is its own flop
  assign ctrl = '{match_flag, count_clock_select, match_irq_enable, prescale_select};
  assign ctrl_wr = wr_ok && (req.addr == PRC_OFS_STATUS_CONTROL);
  assign mod_wr = wr_ok && (req.addr == PRC_OFS_MODULO_VALUE);
  assign clear_flag_wr = ctrl_wr && req.wdata[PRC_BIT_MATCH_FLAG];
  assign wr_clks = req.wdata[PRC_CLKS_LSB +: 2];
  assign wr_ps = req.wdata[PRC_PS_LSB +: 4];
  assign sel_changed = ctrl_wr && ((wr_clks != ctrl.count_clock_select) ||
                                   (wr_ps != ctrl.prescale_select));
  assign counters_clear = sel_changed || mod_wr;

  // ----------------------------------------------------------------
  // source clock sampling
  // ----------------------------------------------------------------
  // the counting clocks are unrelated to the bus clock: two flops, then an edge
  // detector on the second; the divider never sees a raw source level
  logic [2:0] src_meta;
  logic [2:0] src_sync;
  logic [2:0] src_prev;

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      src_meta <= 3'h0;
      src_sync <= 3'h0;
      src_prev <= 3'h0;
    end
    else if (i_clk_en)
    begin
      src_meta <= {i_internal_ref_clock, i_external_ref_clock, i_low_power_osc_clock};
      src_sync <= src_meta;
      src_prev <= src_sync;
    end
  end

  logic [2:0] src_rise;
  logic src_sel_rise;
  logic src_allowed;
  logic step;

  assign src_rise = src_sync & ~src_prev;
  // select bit 1 picks the internal reference, else bit 0 picks low-power or external
  assign src_sel_rise = ctrl.count_clock_select[1] ? src_rise[PRC_SRC_IRC] :
                        (ctrl.count_clock_select[0] ? src_rise[PRC_SRC_EXT] : src_rise[PRC_SRC_LPO]);
  // the internal reference is unusable in deep stop, so its edges are dropped there
  assign src_allowed = !(i_deep_stop_mode && ctrl.count_clock_select[1]);
  // debug suspends the divider too, so counting resumes exactly where it paused
  assign step = src_sel_rise && src_allowed && !i_debug_active;

  // ----------------------------------------------------------------
  // prescaler
  // ----------------------------------------------------------------
  logic [PRC_RATIO_W-1:0] ratio;
  logic tick;

  assign ratio = prc_ratio(ctrl.count_clock_select[0], ctrl.prescale_select);

  prc_prescaler #(
    .RATIO_W(PRC_RATIO_W)
  ) u_prescaler (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_clk_en(i_clk_en),
    .i_step(step),
    .i_clear(counters_clear),
    .i_ratio(ratio),
    .o_tick(tick)
  );

  // ----------------------------------------------------------------
  // counter and compare
  // ----------------------------------------------------------------
  // a tick that meets a clearing write is dropped so the count restarts cleanly
  logic adv;
  logic match;

  assign adv = tick && !counters_clear && !i_debug_active;
  assign match = adv && (count == modulo);

  // no mode input touches the counter or registers: wait, stop and wakeup keep them
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      count <= PRC_COUNT_RESET;
    end
    else if (i_clk_en)
    begin
      if (counters_clear)
      begin
        count <= PRC_COUNT_RESET;
      end
      else if (match)
      begin
        count <= PRC_COUNT_RESET;
      end
      else if (adv)
      begin
        count <= count + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // ----------------------------------------------------------------
  // control and modulo registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      count_clock_select <= PRC_CLKS_RESET;
      match_irq_enable <= 1'b0;
      prescale_select <= PRC_PS_RESET;
    end
    else if (i_clk_en && ctrl_wr)
    begin
      count_clock_select <= wr_clks;
      match_irq_enable <= req.wdata[PRC_BIT_IRQ_ENABLE];
      prescale_select <= wr_ps;
    end
  end

  // set wins over a write-one clear in the same cycle
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      match_flag <= 1'b0;
    end
    else if (i_clk_en)
    begin
      if (match)
      begin
        match_flag <= 1'b1;
      end
      else if (clear_flag_wr)
      begin
        match_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      modulo <= PRC_MODULO_RESET;
    end
    else if (i_clk_en && mod_wr)
    begin
      modulo <= req.wdata;
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  // read data stand for exactly one cycle after the strobe, zero otherwise
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      o_rdata <= 8'h00;
    end
    else if (i_clk_en)
    begin
      if (rd_ok)
      begin
        unique case (req.addr)
          PRC_OFS_STATUS_CONTROL: o_rdata <= ctrl;
          PRC_OFS_COUNT_VALUE: o_rdata <= count;
          PRC_OFS_MODULO_VALUE: o_rdata <= modulo;
          default: o_rdata <= 8'h00;
        endcase
      end
      else
      begin
        o_rdata <= 8'h00;
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupt and adc trigger
  // ----------------------------------------------------------------
  // the request is a level that follows flag and enable; gating the bus clock
  // drops it, software is expected to keep the gate on while counting
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      o_irq <= 1'b0;
    end
    else if (i_clk_en)
    begin
      o_irq <= ctrl.match_flag && ctrl.match_irq_enable && i_bus_clock_gate;
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      o_adc_trigger <= 1'b0;
    end
    else if (i_clk_en)
    begin
      o_adc_trigger <= match && i_adc_hw_trigger_enable;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_match_wrap: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    (i_clk_en && match) |=> (count == PRC_COUNT_RESET) && ctrl.match_flag
  ) else $error("count did not wrap to zero with flag on match");

  a_count_step: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    (i_clk_en && adv && (count != modulo)) |=> (count == $past(count) + 8'h01)
  ) else $error("count did not advance by one on a prescaler tick");

  a_count_hold: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    (i_clk_en && i_debug_active && !counters_clear) |=> $stable(count)
  ) else $error("count changed during background debug");

  a_clear_on_sel: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    (i_clk_en && sel_changed) |=> (count == PRC_COUNT_RESET) && !tick
  ) else $error("select change did not clear counters");

  a_clear_on_mod: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    (i_clk_en && mod_wr) |=> (count == PRC_COUNT_RESET) && (modulo == $past(req.wdata))
  ) else $error("modulo write did not clear count or load value");

  a_flag_clear: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    (i_clk_en && clear_flag_wr && !match) |=> !ctrl.match_flag
  ) else $error("write one did not clear match flag");

  a_flag_set_wins: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    (i_clk_en && clear_flag_wr && match) |=> ctrl.match_flag
  ) else $error("flag set lost against a clear");

  a_adc_trigger: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    (i_clk_en && match && i_adc_hw_trigger_enable) |=> o_adc_trigger ##1 (!o_adc_trigger || !$past(i_clk_en) || $past(match))
  ) else $error("adc trigger missing or stretched on match");

  a_irq_gate: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    (i_clk_en && !i_bus_clock_gate) |=> !o_irq
  ) else $error("interrupt raised with bus clock gated off");

  a_irq_follow: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    (i_clk_en && ctrl.match_flag && ctrl.match_irq_enable && i_bus_clock_gate) |=> o_irq
  ) else $error("interrupt not raised for enabled flag");

  a_deep_stop_irc: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    (i_deep_stop_mode && ctrl.count_clock_select[1]) |-> !step
  ) else $error("internal reference counted in deep stop");

  a_read_count: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    (i_clk_en && rd_ok && (req.addr == PRC_OFS_COUNT_VALUE)) |=> (o_rdata == $past(count))
  ) else $error("count read returned wrong value");

endmodule : prc_top
`default_nettype wire

// *** testbench/prc_top_test.sv ***
// testbench for the periodic real-time counter: a table of register cases, a table of divide ratios,
// then hand-written cases; assumes prc_pkg is compiled first and drives every input at the rising edge
`timescale 1ns/1ps
`default_nettype none
module prc_top_test
  import prc_pkg::*;
;
  // ----------------------------------------------------------------
  // stimulus and observation
  // ----------------------------------------------------------------
  typedef struct {logic [PRC_ADDR_W-1:0] a; logic [7:0] d; logic [7:0] exp;} prc_reg_row_s;
  typedef struct {logic [1:0] clks; logic [3:0] ps; int ratio;} prc_ratio_row_s;
  logic i_ref_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_clk_en = 1'b1;
  logic i_bus_clock_gate = 1'b1;
  logic i_debug_active = 1'b0;
  logic i_deep_stop_mode = 1'b0;
  logic i_adc_hw_trigger_enable = 1'b0;
  logic [2:0] src = 3'h0;
  logic [PRC_ADDR_W-1:0] i_addr = '0;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [7:0] o_rdata;
  logic o_irq;
  logic o_adc_trigger;
  logic [7:0] rv;
  int num_errors = 0;
  int tests_run = 0;
  int adc_seen = 0;
  prc_reg_row_s regs [7] = '{'{2'h0, 8'h7f, 8'h7f}, '{2'h0, 8'h80, 8'h00}, '{2'h2, 8'h55, 8'h55},
    '{2'h2, 8'hff, 8'hff}, '{2'h1, 8'haa, 8'h00}, '{2'h3, 8'h5a, 8'h00}, '{2'h2, 8'h00, 8'h00}};
  prc_ratio_row_s rat [9] = '{'{2'h0, 4'h8, 1}, '{2'h0, 4'h9, 2}, '{2'h0, 4'ha, 4}, '{2'h0, 4'h1, 8},
    '{2'h0, 4'hb, 10}, '{2'h0, 4'hc, 16}, '{2'h2, 4'h9, 2}, '{2'h1, 4'h1, 1024}, '{2'h3, 4'h8, 1000}};

  always #25 i_ref_clk = ~i_ref_clk;

  // the trigger is a one-cycle pulse, so counting edges of it counts matches
  always @(posedge i_ref_clk)
    if (o_adc_trigger === 1'b1)
      adc_seen <= adc_seen + 1;

  prc_top prc_top_i (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_clk_en(i_clk_en),
    .i_bus_clock_gate(i_bus_clock_gate),
    .i_debug_active(i_debug_active),
    .i_deep_stop_mode(i_deep_stop_mode),
    .i_adc_hw_trigger_enable(i_adc_hw_trigger_enable),
    .i_low_power_osc_clock(src[PRC_SRC_LPO]),
    .i_external_ref_clock(src[PRC_SRC_EXT]),
    .i_internal_ref_clock(src[PRC_SRC_IRC]),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .i_wr(i_wr),
    .i_rd(i_rd),
    .o_rdata(o_rdata),
    .o_irq(o_irq),
    .o_adc_trigger(o_adc_trigger)
  );

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : finish_test

  task automatic bus_wr(input logic [PRC_ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask : bus_wr

  // read data stand only in the cycle after the strobe, so sample just past that edge
  task automatic bus_rd(input logic [PRC_ADDR_W-1:0] a, output logic [7:0] d);
    @(posedge i_ref_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask : bus_rd

  // each source pulse is high for 3 bus cycles and low for 4 before the next, above the 2-cycle minimum of the synchroniser
  task automatic pulses(input int which, input int n);
    repeat (n)
    begin
      @(posedge i_ref_clk);
      src[which] <= 1'b1;
      repeat (3) @(posedge i_ref_clk);
      src[which] <= 1'b0;
      repeat (3) @(posedge i_ref_clk);
    end
  endtask : pulses

  task automatic cfg(input logic [7:0] ctrl, input logic [7:0] modv);
    bus_wr(PRC_OFS_MODULO_VALUE, modv);
    bus_wr(PRC_OFS_STATUS_CONTROL, ctrl);
  endtask : cfg

  task automatic expect_count(input logic [7:0] exp);
    bus_rd(PRC_OFS_COUNT_VALUE, rv);
    check(rv, exp);
  endtask : expect_count

  task automatic expect_flag(input logic exp);
    bus_rd(PRC_OFS_STATUS_CONTROL, rv);
    check(rv[PRC_BIT_MATCH_FLAG], exp);
  endtask : expect_flag

  // ----------------------------------------------------------------
  // watchdog: a hang counts as a mismatch
  // ----------------------------------------------------------------
  initial
  begin
    repeat (100000) @(posedge i_ref_clk);
    num_errors++;
    $display("timeout at %0t", $time);
    finish_test();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (20) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    foreach (regs[k])
    begin
      bus_wr(regs[k].a, regs[k].d);
      bus_rd(regs[k].a, rv);
      check(rv, regs[k].exp);
    end
    foreach (rat[k])
    begin
      cfg({1'b1, rat[k].clks, 1'b0, rat[k].ps}, 8'h00);
      pulses((rat[k].clks == 2'h0) ? 0 : ((rat[k].clks == 2'h1) ? 1 : 2), rat[k].ratio - 1);
      expect_flag(1'b0);
      pulses((rat[k].clks == 2'h0) ? 0 : ((rat[k].clks == 2'h1) ? 1 : 2), 1);
      expect_flag(1'b1);
    end
    // count up to the modulo, wrap with flag and trigger while the interrupt is disabled
    @(posedge i_ref_clk);
    i_adc_hw_trigger_enable <= 1'b1;
    cfg(8'h88, 8'h03);
    adc_seen = 0;
    for (int i = 1; i <= 3; i++)
    begin
      pulses(0, 1);
      expect_count(i[7:0]);
    end
    expect_flag(1'b0);
    pulses(0, 1);
    expect_count(8'h00);
    expect_flag(1'b1);
    check(adc_seen, 1);
    check(o_irq, 1'b0);
    // same-value write keeps count and flag; enabling the interrupt raises the request
    pulses(0, 2);
    bus_wr(PRC_OFS_STATUS_CONTROL, 8'h08);
    expect_count(8'h02);
    expect_flag(1'b1);
    bus_wr(PRC_OFS_STATUS_CONTROL, 8'h18);
    repeat (2) @(posedge i_ref_clk);
    #1 check(o_irq, 1'b1);
    // gated bus clock: no request and no register access
    @(posedge i_ref_clk);
    i_bus_clock_gate <= 1'b0;
    bus_wr(PRC_OFS_MODULO_VALUE, 8'h33);
    repeat (2) @(posedge i_ref_clk);
    #1 check(o_irq, 1'b0);
    @(posedge i_ref_clk);
    i_bus_clock_gate <= 1'b1;
    repeat (2) @(posedge i_ref_clk);
    #1 check(o_irq, 1'b1);
    bus_rd(PRC_OFS_MODULO_VALUE, rv);
    check(rv, 8'h03);
    // changed prescaler code clears count; write one clears the flag and request
    bus_wr(PRC_OFS_STATUS_CONTROL, 8'h99);
    expect_count(8'h00);
    expect_flag(1'b0);
    check(o_irq, 1'b0);
    bus_wr(PRC_OFS_STATUS_CONTROL, 8'h18);
    pulses(0, 1);
    expect_count(8'h01);
    bus_wr(PRC_OFS_STATUS_CONTROL, 8'h38);
    expect_count(8'h00);
    // trigger disabled: a match gives no pulse
    @(posedge i_ref_clk);
    i_adc_hw_trigger_enable <= 1'b0;
    cfg(8'h08, 8'h00);
    pulses(0, 1);
    expect_flag(1'b1);
    check(adc_seen, 1);
    // write-one clear in the very cycle of a match: the set wins
    bus_wr(PRC_OFS_STATUS_CONTROL, 8'h88);
    expect_flag(1'b0);
    src[PRC_SRC_LPO] <= 1'b1;
    repeat (3) @(posedge i_ref_clk);
    i_wr <= 1'b1;
    i_addr <= PRC_OFS_STATUS_CONTROL;
    i_wdata <= 8'h88;
    src[PRC_SRC_LPO] <= 1'b0;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
    expect_flag(1'b1);
    // prescaler code zero stops counting
    cfg(8'h80, 8'h00);
    pulses(0, 3);
    expect_flag(1'b0);
    // debug freeze and resume from the held value
    cfg(8'h08, 8'h09);
    pulses(0, 2);
    i_debug_active <= 1'b1;
    pulses(0, 2);
    i_debug_active <= 1'b0;
    expect_count(8'h02);
    pulses(0, 1);
    expect_count(8'h03);
    // clock enable low freezes all state, a register write included
    @(posedge i_ref_clk);
    i_clk_en <= 1'b0;
    pulses(0, 2);
    bus_wr(PRC_OFS_MODULO_VALUE, 8'h44);
    i_clk_en <= 1'b1;
    expect_count(8'h03);
    bus_rd(PRC_OFS_MODULO_VALUE, rv);
    check(rv, 8'h09);
    // deep stop ignores the internal reference but keeps the low-power source
    @(posedge i_ref_clk);
    i_deep_stop_mode <= 1'b1;
    bus_wr(PRC_OFS_STATUS_CONTROL, 8'h48);
    pulses(2, 2);
    expect_count(8'h00);
    bus_wr(PRC_OFS_STATUS_CONTROL, 8'h08);
    pulses(0, 2);
    expect_count(8'h02);
    // second reset in mid-run returns every register to zero
    @(posedge i_ref_clk);
    i_deep_stop_mode <= 1'b0;
    i_rst <= 1'b1;
    repeat (20) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    for (int a = 0; a < 3; a++)
    begin
      bus_rd(a[PRC_ADDR_W-1:0], rv);
      check(rv, 8'h00);
    end
    check(o_irq, 1'b0);
    finish_test();
  end
endmodule : prc_top_test
`default_nettype wire
